//--- core/bnac_nvm_access.sv
/*
 I/O-mapped access control for the byte-wide nonvolatile store: address,
 data, control and status registers, arming window, stalls and ready
 request. Assumes a core that halts while cpuStall is high and a
 calibrated oscillator on oscClk.
*/
// What this block does
// - The store is its own byte-addressable data space.
// - Address, data and control registers sit in I/O space.
// - A read trigger stalls the core for four cycles.
// - A programming trigger stalls the core for two cycles.
// - Mode zero: armed program-enable erases and writes one byte atomically.
// - Program-enable stays set during programming, hardware clears it after.
// - While programming, no other read, erase or write starts.
// - Mode one: armed program-enable erases the byte only.
// - Mode two: armed program-enable writes data without erasing.
// - Erase and write are timed by the calibrated oscillator.
// - A running operation completes through a system reset.
// - Writing one clears a status flag, writing zero leaves it.
// - Bit set and clear touch one bit, only at 0x1F and below.
// - I/O addresses 0x00-0x3F, or plus 0x20 as data space.
// - Master-enable clears itself four cycles after being set.
// - Mode writes are ignored while program-enable is set.
// - While writing, reads and address changes are blocked.
// - Ready request stays high while enabled and store is idle.
`timescale 1ns/1ps
module bnac_nvm_access
   import bnac_pkg::*;
#(
   parameter int ATOMIC_TICKS = ATOMIC_TICKS_DEF,
   parameter int SPLIT_TICKS  = SPLIT_TICKS_DEF
) (
   // Clock and resets
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       porReset_n,
   // Core I/O access
   input  wire logic [7:0] ioAddr,
   input  wire logic       ioDataSpace,
   input  wire logic       ioWrite,
   input  wire logic       ioRead,
   input  wire logic       ioBitSet,
   input  wire logic       ioBitClr,
   input  wire logic [2:0] ioBitNum,
   input  wire logic [7:0] ioWdata,
   output logic      [7:0] ioRdata,
   // Core control
   output logic            cpuStall,
   output logic            readyIrq,
   // Calibrated oscillator
   input  wire logic       oscClk
);

   logic [1:0]            mode_reg, mode_next;
   logic                  rie_reg, rie_next;
   logic [2:0]            mpeCnt_reg, mpeCnt_next;
   logic [NVM_ADDR_W-1:0] addr_reg, addr_next;
   logic [7:0]            data_reg, data_next;
   logic                  doneFlag_reg, doneFlag_next;
   logic                  refusedFlag_reg, refusedFlag_next;
   logic [2:0]            stallCnt_reg, stallCnt_next;
   logic [7:0]            ioRdata_reg, ioRdata_next;
   logic [6:0]            acc;
   logic                  accOk, bitOp, bitOk, wrEn, mpeArmed;
   logic [5:0]            idx;
   logic [7:0]            wrMask, wrVal, wrBits;
   logic                  ctrlWr, statWr, peReq, reReq;
   logic                  startOp, readOp, storeBusy, storeDone;
   logic [7:0]            storeRd;
   logic [7:0]            ctrlView;

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   // Returns {valid, I/O index}; data-space addresses carry the offset
   function automatic logic [6:0] decodeIo(input logic [7:0] a,
                                           input logic       ds);
      logic [7:0] d;
      d = a - DS_IO_OFFSET;
      if (ds) begin
         decodeIo = {(a >= DS_IO_OFFSET && a <= DS_IO_LAST), d[5:0]};
      end else begin
         decodeIo = {(a[7:6] == 2'h0), a[5:0]};
      end
   endfunction

   function automatic logic [7:0] regRead(input logic [5:0] i);
      if (i == REG_CTRL) begin
         regRead = {2'h0, mode_reg, rie_reg, mpeArmed, storeBusy, 1'b0};
      end else if (i == REG_STATUS) begin
         regRead = {6'h0, refusedFlag_reg, doneFlag_reg};
      end else if (i == REG_DATA) begin
         regRead = data_reg;
      end else if (i == REG_ADDRL) begin
         regRead = addr_reg[7:0];
      end else if (i == REG_ADDRH) begin
         regRead = {7'h0, addr_reg[NVM_ADDR_W-1]};
      end else begin
         regRead = 8'h00;
      end
   endfunction

   assign acc      = decodeIo(ioAddr, ioDataSpace);
   assign accOk    = acc[6];
   assign idx      = acc[5:0];
   assign bitOp    = ioBitSet | ioBitClr;
   assign bitOk    = bitOp && accOk && (idx <= IO_BIT_LIMIT);
   assign wrEn     = (ioWrite && accOk) || bitOk;
   // A bit instruction writes one bit only, so other flags are safe
   assign wrMask   = bitOk ? (8'h01 << ioBitNum) : 8'hff;
   assign wrVal    = bitOk ? {8{ioBitSet}} : ioWdata;
   assign wrBits   = wrMask & wrVal;
   assign ctrlWr   = wrEn && (idx == REG_CTRL);
   assign statWr   = wrEn && (idx == REG_STATUS);
   assign mpeArmed = (mpeCnt_reg != 3'h0);
   assign peReq    = ctrlWr && wrBits[CTL_PE];
   assign reReq    = ctrlWr && wrBits[CTL_RE];
   assign startOp  = peReq && mpeArmed && !storeBusy &&
                     (mode_reg != MODE_RSVD);
   assign readOp   = reReq && !storeBusy && !startOp;

   // ------------------------------------------------------------------
   // Register next values
   // ------------------------------------------------------------------
   always_comb begin
      mode_next        = mode_reg;
      rie_next         = rie_reg;
      mpeCnt_next      = mpeArmed ? mpeCnt_reg - 3'h1 : 3'h0;
      addr_next        = addr_reg;
      data_next        = data_reg;
      refusedFlag_next = refusedFlag_reg;
      ioRdata_next     = ioRdata_reg;
      if (ctrlWr && wrMask[CTL_MPE]) begin
         mpeCnt_next = wrVal[CTL_MPE] ? MPE_WINDOW : 3'h0;
      end
      if (ctrlWr && !storeBusy && !startOp) begin
         if (wrMask[CTL_PM0]) mode_next[0] = wrVal[CTL_PM0];
         if (wrMask[CTL_PM1]) mode_next[1] = wrVal[CTL_PM1];
      end
      if (ctrlWr && wrMask[CTL_RIE]) begin
         rie_next = wrVal[CTL_RIE];
      end
      if (wrEn && !storeBusy) begin
         if (idx == REG_ADDRL) begin
            addr_next[7:0] = (addr_reg[7:0] & ~wrMask) | wrBits;
         end else if (idx == REG_ADDRH && wrMask[0]) begin
            addr_next[NVM_ADDR_W-1] = wrVal[0];
         end
      end
      if (wrEn && idx == REG_DATA) begin
         data_next = (data_reg & ~wrMask) | wrBits;
      end
      if (readOp) begin
         data_next = storeRd;
      end
      // Set wins over a simultaneous clear
      doneFlag_next = storeDone ||
                      (doneFlag_reg && !(statWr && wrBits[STAT_DONE]));
      if (statWr && wrBits[STAT_REFUSED]) begin
         refusedFlag_next = 1'b0;
      end
      if ((peReq || reReq) && storeBusy) begin
         refusedFlag_next = 1'b1;
      end
      if (readOp) begin
         stallCnt_next = READ_STALL;
      end else if (startOp) begin
         stallCnt_next = PROG_STALL;
      end else if (stallCnt_reg != 3'h0) begin
         stallCnt_next = stallCnt_reg - 3'h1;
      end else begin
         stallCnt_next = 3'h0;
      end
      if (ioRead && accOk) begin
         ioRdata_next = regRead(idx);
      end
   end

   // System reset spares the mode and address of a running operation
   always_ff @(posedge mclk) begin
      if (!porReset_n) begin
         mode_reg        <= MODE_ATOMIC;
         addr_reg        <= '0;
         rie_reg         <= 1'b0;
         mpeCnt_reg      <= 3'h0;
         data_reg        <= 8'h00;
         doneFlag_reg    <= 1'b0;
         refusedFlag_reg <= 1'b0;
         stallCnt_reg    <= 3'h0;
         ioRdata_reg     <= 8'h00;
      end else if (!reset_n) begin
         if (!storeBusy) begin
            mode_reg <= MODE_ATOMIC;
         end
         rie_reg         <= 1'b0;
         mpeCnt_reg      <= 3'h0;
         data_reg        <= 8'h00;
         doneFlag_reg    <= 1'b0;
         refusedFlag_reg <= 1'b0;
         stallCnt_reg    <= 3'h0;
         ioRdata_reg     <= 8'h00;
      end else begin
         mode_reg        <= mode_next;
         rie_reg         <= rie_next;
         mpeCnt_reg      <= mpeCnt_next;
         addr_reg        <= addr_next;
         data_reg        <= data_next;
         doneFlag_reg    <= doneFlag_next;
         refusedFlag_reg <= refusedFlag_next;
         stallCnt_reg    <= stallCnt_next;
         ioRdata_reg     <= ioRdata_next;
      end
   end

   // ------------------------------------------------------------------
   // Store and outputs
   // ------------------------------------------------------------------
   bnac_nvm_store #(
      .ATOMIC_TICKS (ATOMIC_TICKS),
      .SPLIT_TICKS  (SPLIT_TICKS)
   ) u_store (
      .mclk       (mclk),
      .porReset_n (porReset_n),
      .oscClk     (oscClk),
      .startOp    (startOp),
      .startMode  (mode_reg),
      .startAddr  (addr_reg),
      .startData  (data_reg),
      .rdAddr     (addr_reg),
      .rdData     (storeRd),
      .busy       (storeBusy),
      .done       (storeDone)
   );

   assign ioRdata  = ioRdata_reg;
   assign ctrlView = regRead(REG_CTRL);
   assign cpuStall = (stallCnt_reg != 3'h0);
   // Program-enable reads back as the store's busy state
   assign readyIrq = rie_reg && !storeBusy;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n || !porReset_n);

   a_read_stall: assert property (
      readOp |=> cpuStall [*4] ##1 !cpuStall)
      else $error("read stall is not four cycles");
   a_prog_stall: assert property (
      startOp |=> cpuStall [*2] ##1 !cpuStall)
      else $error("program stall is not two cycles");
   a_start_busy: assert property (
      startOp |=> storeBusy && ctrlView[CTL_PE])
      else $error("program-enable not set after start");
   a_unarmed_pe: assert property (
      peReq && !mpeArmed && !storeBusy |=> !storeBusy)
      else $error("unarmed program-enable started an operation");
   a_busy_read: assert property (
      storeBusy && reReq && !(wrEn && idx == REG_DATA) |=> $stable(data_reg))
      else $error("read taken while programming");
   a_mode_hold: assert property (
      storeBusy |=> $stable(mode_reg))
      else $error("mode changed while programming");
   a_addr_hold: assert property (
      storeBusy |=> $stable(addr_reg))
      else $error("address changed while programming");
   a_ready_irq: assert property (
      rie_reg && storeDone |-> readyIrq ##1 (readyIrq || !rie_reg))
      else $error("ready request missing after completion");
   a_done_keep: assert property (
      doneFlag_reg && statWr && !wrBits[STAT_DONE] |=> doneFlag_reg)
      else $error("done flag lost on zero write");
   a_bit_range: assert property (
      bitOp && !ioWrite && accOk && idx > IO_BIT_LIMIT |=>
         $stable(data_reg) && $stable(addr_reg))
      else $error("bit instruction accepted above 0x1f");
   a_mpe_expire: assert property (
      ctrlWr && wrBits[CTL_MPE] ##1 !(ctrlWr && wrMask[CTL_MPE]) [*4]
         |=> !mpeArmed)
      else $error("master-enable not cleared after four cycles");

   c_atomic: cover property (startOp && mode_reg == MODE_ATOMIC);
   c_erase:  cover property (startOp && mode_reg == MODE_ERASE);
   c_read:   cover property (readOp);
   c_refuse: cover property (peReq && storeBusy);

endmodule

//--- core/bnac_pkg.sv
/*
 Constants shared by the byte-wide nonvolatile access block: I/O map,
 control and status bit positions, programming modes and timing.
 Assumes a processor core that issues 6-bit I/O accesses on mclk.
*/
package bnac_pkg;

   // ------------------------------------------------------------------
   // I/O space
   // ------------------------------------------------------------------
   localparam logic [7:0] DS_IO_OFFSET = 8'h20;
   localparam logic [7:0] DS_IO_LAST   = 8'h5f;
   localparam logic [5:0] IO_BIT_LIMIT = 6'h1f;
   localparam logic [5:0] REG_STATUS   = 6'h1e;
   localparam logic [5:0] REG_CTRL     = 6'h1f;
   localparam logic [5:0] REG_DATA     = 6'h20;
   localparam logic [5:0] REG_ADDRL    = 6'h21;
   localparam logic [5:0] REG_ADDRH    = 6'h22;

   // ------------------------------------------------------------------
   // Control and status bits
   // ------------------------------------------------------------------
   localparam int CTL_RE   = 0;
   localparam int CTL_PE   = 1;
   localparam int CTL_MPE  = 2;
   localparam int CTL_RIE  = 3;
   localparam int CTL_PM0  = 4;
   localparam int CTL_PM1  = 5;
   localparam int STAT_DONE    = 0;
   localparam int STAT_REFUSED = 1;

   // ------------------------------------------------------------------
   // Store geometry and modes
   // ------------------------------------------------------------------
   localparam int         NVM_ADDR_W  = 9;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   typedef enum logic [1:0] {
      MODE_ATOMIC = 2'h0,
      MODE_ERASE  = 2'h1,
      MODE_WRITE  = 2'h2,
      MODE_RSVD   = 2'h3
   } bnac_mode_e;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam logic [2:0] READ_STALL  = 3'h4;
   localparam logic [2:0] PROG_STALL  = 3'h2;
   localparam logic [2:0] MPE_WINDOW  = 3'h4;
   localparam int ATOMIC_TIME_US = 3400;
   localparam int SPLIT_TIME_US  = 1800;
   localparam int OSC_FREQ_KHZ   = 8000;
   localparam int ATOMIC_TICKS_DEF = ATOMIC_TIME_US * OSC_FREQ_KHZ / 1000;
   localparam int SPLIT_TICKS_DEF  = SPLIT_TIME_US * OSC_FREQ_KHZ / 1000;
   localparam int TICK_W = 20;

endpackage

//--- core/bnac_nvm_store.sv
/*
 Byte array of the nonvolatile store with its self-timed programming
 engine. Assumes oscClk is the calibrated oscillator, asynchronous to
 mclk, and that only the power-on reset may abort an operation.
*/
`timescale 1ns/1ps
module bnac_nvm_store
   import bnac_pkg::*;
#(
   parameter int ATOMIC_TICKS = ATOMIC_TICKS_DEF,
   parameter int SPLIT_TICKS  = SPLIT_TICKS_DEF
) (
   // Clock and power-on reset
   input  wire logic                  mclk,
   input  wire logic                  porReset_n,
   // Calibrated oscillator
   input  wire logic                  oscClk,
   // Operation start
   input  wire logic                  startOp,
   input  wire logic [1:0]            startMode,
   input  wire logic [NVM_ADDR_W-1:0] startAddr,
   input  wire logic [7:0]            startData,
   // Read port
   input  wire logic [NVM_ADDR_W-1:0] rdAddr,
   output logic      [7:0]            rdData,
   // Status
   output logic                      busy,
   output logic                      done
);

   if (ATOMIC_TICKS < 1 || SPLIT_TICKS < 1 ||
       ATOMIC_TICKS >= (1 << TICK_W) || SPLIT_TICKS >= (1 << TICK_W)) begin
      $error("bnac_nvm_store: tick counts out of range");
   end

   typedef enum logic {ST_IDLE, ST_PROG} bnac_state_e;

   logic [7:0]            mem [0:(1<<NVM_ADDR_W)-1];
   logic                  oscMeta_reg, oscSync_reg, oscPrev_reg;
   bnac_state_e           state_reg, state_next;
   logic [TICK_W-1:0]     timer_reg, timer_next;
   logic [1:0]            mode_reg, mode_next;
   logic [NVM_ADDR_W-1:0] addr_reg, addr_next;
   logic [7:0]            data_reg, data_next;
   logic                  done_reg, done_next;
   logic                  oscTick;
   logic                  memWr;
   logic [7:0]            memVal;

   // ------------------------------------------------------------------
   // Oscillator tick
   // ------------------------------------------------------------------
   // Edge detect reads the second and third stages, never the first.
   assign oscTick = oscSync_reg & ~oscPrev_reg;

   // ------------------------------------------------------------------
   // Programming engine
   // ------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      mode_next  = mode_reg;
      addr_next  = addr_reg;
      data_next  = data_reg;
      done_next  = 1'b0;
      memWr      = 1'b0;
      memVal     = data_reg;
      case (state_reg)
         ST_IDLE: begin
            if (startOp) begin
               state_next = ST_PROG;
               mode_next  = startMode;
               addr_next  = startAddr;
               data_next  = startData;
               timer_next = (startMode == MODE_ATOMIC) ?
                            TICK_W'(ATOMIC_TICKS) : TICK_W'(SPLIT_TICKS);
            end
         end
         ST_PROG: begin
            if (oscTick) begin
               if (timer_reg <= TICK_W'(1)) begin
                  state_next = ST_IDLE;
                  done_next  = 1'b1;
                  memWr      = 1'b1;
                  case (mode_reg)
                     MODE_ERASE: memVal = ERASED_BYTE;
                     // Unerased target: bits only fall, value is lost
                     MODE_WRITE: memVal = mem[addr_reg] & data_reg;
                     default:    memVal = data_reg;
                  endcase
               end else begin
                  timer_next = timer_reg - TICK_W'(1);
               end
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // System reset is not seen here, so a running operation completes
   always_ff @(posedge mclk) begin
      oscMeta_reg <= oscClk;
      oscSync_reg <= oscMeta_reg;
      oscPrev_reg <= oscSync_reg;
      if (!porReset_n) begin
         state_reg <= ST_IDLE;
         timer_reg <= '0;
         mode_reg  <= '0;
         addr_reg  <= '0;
         data_reg  <= '0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         mode_reg  <= mode_next;
         addr_reg  <= addr_next;
         data_reg  <= data_next;
         done_reg  <= done_next;
      end
   end

   // Byte-addressable array, separate from every other memory
   always_ff @(posedge mclk) begin
      if (memWr) begin
         mem[addr_reg] <= memVal;
      end
   end

   assign rdData = mem[rdAddr];
   assign busy   = (state_reg == ST_PROG);
   assign done   = done_reg;

endmodule

//--- tb/bnac_core_model.sv
/*
 Core model: issues I/O writes, reads and single-bit operations.
 Assumes the access block halts it through cpuStall.
*/
`timescale 1ns/1ps
module bnac_core_model
   import bnac_pkg::*;
(
   // Clock and core control
   input  wire logic       mclk,
   input  wire logic       cpuStall,
   input  wire logic [7:0] ioRdata,
   // I/O access
   output logic      [7:0] ioAddr,
   output logic            ioDataSpace,
   output logic            ioWrite,
   output logic            ioRead,
   output logic            ioBitSet,
   output logic            ioBitClr,
   output logic      [2:0] ioBitNum,
   output logic      [7:0] ioWdata
);
   initial begin
      {ioAddr, ioDataSpace, ioWrite, ioRead} = '0;
      {ioBitSet, ioBitClr, ioBitNum, ioWdata} = '0;
   end
   // Halts while stalled, as the real core does; bounded
   task automatic go();
      int n;
      n = 0;
      @(negedge mclk);
      while (cpuStall === 1'b1 && n < 50) begin
         n++;
         @(negedge mclk);
      end
      if (n == 50) begin
         testbench.err_count++;
         $display("BAD %0t core stalled too long", $time);
      end
   endtask
   // Released lines show garbage, never the last value
   task automatic rel();
      @(negedge mclk);
      {ioWrite, ioRead, ioBitSet, ioBitClr, ioDataSpace} <= '0;
      ioAddr <= ~ioAddr;
      ioWdata <= ~ioWdata;
      ioBitNum <= ~ioBitNum;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic ds);
      go();
      ioAddr <= a;
      ioWdata <= d;
      ioDataSpace <= ds;
      ioWrite <= 1'b1;
      rel();
   endtask
   task automatic rd(input logic [7:0] a, input logic ds,
                     output logic [7:0] d);
      go();
      ioAddr <= a;
      ioDataSpace <= ds;
      ioRead <= 1'b1;
      rel();
      d = ioRdata;
   endtask
   task automatic bit_op(input logic s, input logic [7:0] a,
                         input logic [2:0] n);
      go();
      ioAddr <= a;
      ioBitNum <= n;
      if (s) ioBitSet <= 1'b1;
      else ioBitClr <= 1'b1;
      rel();
   endtask
endmodule

//--- tb/testbench.sv
/*
 Self-checking bench for the nonvolatile access block with a byte
 model of the store. Assumes short tick counts and a free oscillator.
*/
`timescale 1ns/1ps
module testbench;
   import bnac_pkg::*;
   logic       mclk, reset_n, porReset_n, oscClk;
   logic [7:0] ioAddr, ioWdata, ioRdata, rv, d;
   logic       ioDataSpace, ioWrite, ioRead, ioBitSet, ioBitClr;
   logic [2:0] ioBitNum;
   logic       cpuStall, readyIrq, rie;
   int         err_count, cmp_count, st, a;
   int         mem [int];

   bnac_nvm_access #(.ATOMIC_TICKS(4), .SPLIT_TICKS(2))
      bnac_nvm_access_inst (.mclk(mclk), .reset_n(reset_n),
      .porReset_n(porReset_n), .ioAddr(ioAddr), .ioDataSpace(ioDataSpace),
      .ioWrite(ioWrite), .ioRead(ioRead), .ioBitSet(ioBitSet),
      .ioBitClr(ioBitClr), .ioBitNum(ioBitNum), .ioWdata(ioWdata),
      .ioRdata(ioRdata), .cpuStall(cpuStall), .readyIrq(readyIrq),
      .oscClk(oscClk));
   bnac_core_model bnac_core_model_inst (.mclk(mclk), .cpuStall(cpuStall),
      .ioRdata(ioRdata), .ioAddr(ioAddr), .ioDataSpace(ioDataSpace),
      .ioWrite(ioWrite), .ioRead(ioRead), .ioBitSet(ioBitSet),
      .ioBitClr(ioBitClr), .ioBitNum(ioBitNum), .ioWdata(ioWdata));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      oscClk = 1'b0;
      forever #47 oscClk = ~oscClk;
   end
   initial begin
      #500000;
      err_count++;
      $display("BAD %0t run too long", $time);
      tally_and_finish();
   end

   // ------------------------------------------------------------------
   // Checks and software sequences
   // ------------------------------------------------------------------
   task automatic tally_and_finish();
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkn(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         err_count++;
         $display("BAD %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic w(input logic [5:0] x, input logic [7:0] v);
      bnac_core_model_inst.wr({2'b00, x}, v, 1'b0);
   endtask
   task automatic r(input logic [5:0] x, output logic [7:0] v);
      bnac_core_model_inst.rd({2'b00, x}, 1'b0, v);
   endtask
   task automatic b(input logic s, input logic [5:0] x, input int n);
      bnac_core_model_inst.bit_op(s, {2'b00, x}, 3'(n));
   endtask
   task automatic stalls(output int n);
      n = 0;
      while (cpuStall === 1'b1 && n < 20) begin
         n++;
         @(negedge mclk);
      end
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      r(REG_CTRL, rv);
      while (rv[CTL_PE] !== 1'b0 && n < 100) begin
         n++;
         r(REG_CTRL, rv);
      end
      if (n == 100) begin
         err_count++;
         $display("BAD %0t store never idle", $time);
         tally_and_finish();
      end
   endtask
   task automatic set_addr(input int ad);
      w(REG_ADDRH, {7'h00, ad[8]});
      w(REG_ADDRL, ad[7:0]);
   endtask
   task automatic prog(input logic [1:0] m, input int ad,
                       input logic [7:0] v);
      wait_idle();
      w(REG_CTRL, {2'b00, m, rie, 3'b000});
      set_addr(ad);
      w(REG_DATA, v);
      w(REG_CTRL, {2'b00, m, rie, 3'b100});
      w(REG_CTRL, {2'b00, m, rie, 3'b110});
      stalls(st);
      chkn(st, 2);
      r(REG_CTRL, rv);
      chk8(rv & 8'h02, 8'h02);
      mem[ad] = (m == 2'b00) ? v : (m == 2'b01) ? 255 : mem[ad] & v;
   endtask
   task automatic rdb(input int ad);
      wait_idle();
      set_addr(ad);
      w(REG_CTRL, {4'h0, rie, 3'b001});
      stalls(st);
      chkn(st, 4);
      r(REG_DATA, rv);
      chk8(rv, 8'(mem[ad]));
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      porReset_n = 1'b0;
      {err_count, cmp_count, rie} = '0;
      void'($urandom(8));
      repeat (2) @(negedge mclk);
      {reset_n, porReset_n} = 2'b11;
      r(REG_CTRL, rv);
      chk8(rv, 8'h00);
      r(REG_DATA, rv);
      chk8({rv[7:1], readyIrq}, 8'h00);
      for (int i = 0; i < 3; i++) begin
         a = int'($urandom % 512);
         d = 8'($urandom);
         prog(2'b01, a, 8'h00);
         rdb(a);
         prog(2'b10, a, d);
         rdb(a);
         prog(2'b00, a, ~d);
         rdb(a);
      end
      wait_idle();
      r(REG_STATUS, rv);
      chk8(rv & 8'h01, 8'h01);
      w(REG_STATUS, 8'h00);
      r(REG_STATUS, rv);
      chk8(rv & 8'h01, 8'h01);
      w(REG_STATUS, 8'h03);
      r(REG_STATUS, rv);
      chk8(rv, 8'h00);
      // Accesses while busy must bounce off, except the master-enable and ready-enable bit writes
      rie = 1'b1;
      w(REG_CTRL, 8'h08);
      chk8({7'h00, readyIrq}, 8'h01);
      prog(2'b00, a, 8'h5a);
      chk8({7'h00, readyIrq}, 8'h00);
      set_addr(a ^ 3);
      w(REG_CTRL, {4'h1, rie, 3'b001});
      w(REG_CTRL, {4'h1, rie, 3'b100});
      w(REG_CTRL, {4'h1, rie, 3'b110});
      wait_idle();
      chk8({7'h00, readyIrq}, 8'h01);
      r(REG_ADDRL, rv);
      chk8(rv, 8'(a));
      r(REG_CTRL, rv);
      chk8(rv & 8'h30, 8'h00);
      r(REG_STATUS, rv);
      chk8(rv & 8'h02, 8'h02);
      r(REG_DATA, rv);
      chk8(rv, 8'h5a);
      rdb(a);
      w(REG_CTRL, {4'h0, rie, 3'b010});
      r(REG_CTRL, rv);
      chk8(rv & 8'h06, 8'h00);
      w(REG_CTRL, {4'h3, rie, 3'b100});
      w(REG_CTRL, {4'h3, rie, 3'b110});
      r(REG_CTRL, rv);
      chk8(rv & 8'h02, 8'h00);
      // Mode zero here, so only the expired window can stop a start
      w(REG_CTRL, {4'h0, rie, 3'b100});
      repeat (5) @(negedge mclk);
      b(1'b1, REG_CTRL, CTL_PE);
      r(REG_CTRL, rv);
      chk8(rv & 8'h06, 8'h00);
      // Bit operations arm and start; a system reset must not abort
      w(REG_CTRL, {4'h0, rie, 3'b000});
      w(REG_DATA, 8'hc3);
      b(1'b1, REG_CTRL, CTL_MPE);
      b(1'b1, REG_CTRL, CTL_PE);
      mem[a] = 8'hc3;
      b(1'b0, REG_CTRL, CTL_RIE);
      r(REG_CTRL, rv);
      chk8(rv & 8'h0a, 8'h02);
      reset_n = 1'b0;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      rie = 1'b0;
      rdb(a);
      bnac_core_model_inst.wr(DS_IO_OFFSET + 8'(REG_DATA), 8'h81, 1'b1);
      r(REG_DATA, rv);
      chk8(rv, 8'h81);
      b(1'b1, REG_DATA, 1);
      b(1'b0, REG_DATA, 0);
      bnac_core_model_inst.rd(DS_IO_OFFSET + 8'(REG_DATA), 1'b1, rv);
      chk8(rv, 8'h81);
      tally_and_finish();
   end
endmodule
